/* File: inc/wgc_regs.svh */
/*
  Register map, field positions and reset values of the waveform generator
  control block. Assumes it is included by bare name and sits on the include path.
*/
`ifndef WGC_REGS_SVH
`define WGC_REGS_SVH

// -----------------------------------------------------------------
// Register addresses
// -----------------------------------------------------------------
`define WGC_ADDR_W 3
`define WGC_ADDR_CTRL0 3'h0
`define WGC_ADDR_CTRL1 3'h1
`define WGC_ADDR_DB_RISE 3'h2
`define WGC_ADDR_DB_FALL 3'h3
`define WGC_ADDR_STEER 3'h4

// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define WGC_BIT_ENABLE 7
`define WGC_BIT_LOAD 6
`define WGC_MODE_MSB 2
`define WGC_BIT_IN_VALUE 5
`define WGC_POL_MSB 3
`define WGC_DB_MSB 5
`define WGC_STEER_MSB 3
`define WGC_DB_W 6

// -----------------------------------------------------------------
// Mode encodings and reset values
// -----------------------------------------------------------------
`define WGC_MODE_STEER_CODE 3'h0
`define WGC_MODE_SYNC_STEER_CODE 3'h1
`define WGC_MODE_FWD_CODE 3'h2
`define WGC_MODE_REV_CODE 3'h3
`define WGC_MODE_HALF_CODE 3'h4
`define WGC_MODE_PUSH_PULL_CODE 3'h5
`define WGC_MODE_RSV6_CODE 3'h6
`define WGC_MODE_RSV7_CODE 3'h7
`define WGC_READ_ZERO 8'h00
`define WGC_OUT_OFF 4'h0

`endif

/* File: inc/wgc_pkg.sv */
/*
  Types of the waveform generator control block: mode enumeration and the
  state records of the control module and the dead-band timer.
  Assumes wgc_regs.svh is on the include path.
*/
`include "wgc_regs.svh"

package wgc_pkg;

  typedef enum logic [2:0] {
    WGC_MODE_STEER = `WGC_MODE_STEER_CODE,
    WGC_MODE_SYNC_STEER = `WGC_MODE_SYNC_STEER_CODE,
    WGC_MODE_FWD = `WGC_MODE_FWD_CODE,
    WGC_MODE_REV = `WGC_MODE_REV_CODE,
    WGC_MODE_HALF = `WGC_MODE_HALF_CODE,
    WGC_MODE_PUSH_PULL = `WGC_MODE_PUSH_PULL_CODE,
    WGC_MODE_RSV6 = `WGC_MODE_RSV6_CODE,
    WGC_MODE_RSV7 = `WGC_MODE_RSV7_CODE
  } wgc_mode_t;

  typedef struct packed {
    logic enable;
    logic load_req;
    wgc_mode_t mode;
    logic [3:0] pol;
    logic [3:0] steer_buf;
    logic [3:0] steer_act;
    logic pp_phase;
    logic in_meta;
    logic in_sync;
    logic in_prev;
    logic [3:0] out;
    logic [7:0] rdata;
  } wgc_ctrl_state_t;

  typedef struct packed {
    logic [5:0] rise_buf;
    logic [5:0] fall_buf;
    logic [5:0] rise_act;
    logic [5:0] fall_act;
  } wgc_db_state_t;

  typedef struct packed {
    logic prev;
    logic [5:0] cnt;
    logic hi;
    logic lo;
  } wgc_timer_state_t;

endpackage

/* File: src/wgc_deadband.sv */
/*
  Dead-band timer: delays the high and the low phase of a level by separate
  cycle counts. Assumes the level is already synchronous to clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none

module wgc_deadband
  import wgc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic level,
  input wire logic [5:0] rise_cnt,
  input wire logic [5:0] fall_cnt,
  output logic hi_q,
  output logic lo_q
);

  wgc_timer_state_t st_q;
  wgc_timer_state_t st_d;

  // -----------------------------------------------------------------
  // Timer
  // -----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.prev = level;
    if (level != st_q.prev) begin
      st_d.cnt = 6'h00;
      st_d.hi = level && (rise_cnt == 6'h00);
      st_d.lo = !level && (fall_cnt == 6'h00);
    end else begin
      // The done flags are sticky so that a count that was still unknown
      // after power-on resolves once software writes it.
      st_d.cnt = 6'(st_q.cnt + 6'h01);
      if (level) begin
        st_d.hi = st_q.hi || (6'(st_q.cnt + 6'h01) == rise_cnt);
      end else begin
        st_d.lo = st_q.lo || (6'(st_q.cnt + 6'h01) == fall_cnt);
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign hi_q = st_q.hi;
  assign lo_q = st_q.lo;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  rise_delay_count_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    $rose(st_q.hi) |-> st_q.cnt == $past(rise_cnt))
    else $error("rising dead-band delay differs from the programmed count");

  fall_delay_count_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    $rose(st_q.lo) |-> st_q.cnt == $past(fall_cnt))
    else $error("falling dead-band delay differs from the programmed count");

  rise_hold_off_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (level && !st_q.prev && rise_cnt == 6'h02)
      |=> !st_q.hi ##1 !st_q.hi ##1 (st_q.hi || !level))
    else $error("output asserted before the rising dead-band expired");

endmodule

`default_nettype wire

/* File: src/wgc_ctrl.sv */
/*
  Control registers and output steering of a complementary waveform generator:
  enable, buffered load, mode, polarity, steering and dead-band counts.
  Assumes a one-cycle register port on clk_sys and an asynchronous wave_in pin.
*/
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none

`include "wgc_regs.svh"

// Operation
// - The enable bit turns the generator on when one and holds all outputs off when zero.
// - Writing one to the load request moves buffered settings to the active set at the next input edge, then hardware clears it.
// - The load request is only taken while the module is already enabled, never in the write that enables it.
// - Mode 101 gives push-pull outputs and mode 100 gives half-bridge outputs.
// - Mode 011 gives a reverse full bridge and mode 010 a forward full bridge.
// - Mode 001 is synchronous steering, 000 plain steering, and 110 and 111 are reserved.
// - Each of the four outputs has its own polarity bit, one inverting it.
// - A six-bit field of the rising dead-band register supplies the rising-event count.
// - Unimplemented register bits ignore writes and read as zero.
// - Control bits reset to zero while dead-band counts keep their value across resets.
// - In plain steering a steering change takes effect at once.
// - In synchronous steering a steering change waits for the next rising input edge.
// - A separate six-bit field holds the falling-event dead-band count.
module wgc_ctrl
  import wgc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic wave_in,
  output logic [3:0] wave_out
);

  wgc_ctrl_state_t st_q;
  wgc_ctrl_state_t st_d;
  wgc_db_state_t db_q;
  wgc_db_state_t db_d;
  logic db_hi;
  logic db_lo;
  logic rise_evt;
  logic edge_evt;
  logic [3:0] bridge;
  logic [3:0] raw;

  assign rise_evt = st_q.in_sync && !st_q.in_prev;
  assign edge_evt = st_q.in_sync != st_q.in_prev;

  // -----------------------------------------------------------------
  // Dead-band timer
  // -----------------------------------------------------------------
  wgc_deadband u_deadband (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .level(st_q.in_sync),
    .rise_cnt(db_q.rise_act),
    .fall_cnt(db_q.fall_act),
    .hi_q(db_hi),
    .lo_q(db_lo)
  );

  // -----------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    db_d = db_q;
    st_d.rdata = `WGC_READ_ZERO;
    st_d.in_meta = wave_in;
    st_d.in_sync = st_q.in_meta;
    st_d.in_prev = st_q.in_sync;

    // Synchronous steering holds the old selection until a rising edge so
    // that only whole pulses reach the pins.
    if (st_q.mode == WGC_MODE_SYNC_STEER) begin
      if (rise_evt) begin
        st_d.steer_act = st_q.steer_buf;
      end
    end else begin
      st_d.steer_act = st_q.steer_buf;
    end

    if (rise_evt) begin
      st_d.pp_phase = !st_q.pp_phase;
    end

    // While disabled the active counts track the buffers, so a fresh enable
    // starts with what software last wrote.
    if (!st_q.enable) begin
      db_d.rise_act = db_q.rise_buf;
      db_d.fall_act = db_q.fall_buf;
      st_d.load_req = 1'b0;
    end else if (st_q.load_req && edge_evt) begin
      db_d.rise_act = db_q.rise_buf;
      db_d.fall_act = db_q.fall_buf;
      st_d.load_req = 1'b0;
    end

    // A write that sets the request wins over the hardware clear above.
    if (reg_wr) begin
      if (reg_addr == `WGC_ADDR_CTRL0) begin
        st_d.enable = reg_wdata[`WGC_BIT_ENABLE];
        st_d.mode = wgc_mode_t'(reg_wdata[`WGC_MODE_MSB:0]);
        if (st_q.enable && reg_wdata[`WGC_BIT_LOAD]) begin
          st_d.load_req = 1'b1;
        end
      end else if (reg_addr == `WGC_ADDR_CTRL1) begin
        st_d.pol = reg_wdata[`WGC_POL_MSB:0];
      end else if (reg_addr == `WGC_ADDR_DB_RISE) begin
        db_d.rise_buf = reg_wdata[`WGC_DB_MSB:0];
      end else if (reg_addr == `WGC_ADDR_DB_FALL) begin
        db_d.fall_buf = reg_wdata[`WGC_DB_MSB:0];
      end else if (reg_addr == `WGC_ADDR_STEER) begin
        st_d.steer_buf = reg_wdata[`WGC_STEER_MSB:0];
      end
    end

    if (reg_rd) begin
      if (reg_addr == `WGC_ADDR_CTRL0) begin
        st_d.rdata = {st_q.enable, st_q.load_req, 3'h0, st_q.mode};
      end else if (reg_addr == `WGC_ADDR_CTRL1) begin
        st_d.rdata = {2'h0, st_q.in_sync, 1'b0, st_q.pol};
      end else if (reg_addr == `WGC_ADDR_DB_RISE) begin
        st_d.rdata = {2'h0, db_q.rise_buf};
      end else if (reg_addr == `WGC_ADDR_DB_FALL) begin
        st_d.rdata = {2'h0, db_q.fall_buf};
      end else if (reg_addr == `WGC_ADDR_STEER) begin
        st_d.rdata = {4'h0, st_q.steer_buf};
      end else begin
        st_d.rdata = `WGC_READ_ZERO;
      end
    end

    // Output order is {D, C, B, A}.
    bridge = `WGC_OUT_OFF;
    case (st_q.mode)
      WGC_MODE_HALF: begin
        bridge = {db_lo, db_hi, db_lo, db_hi};
      end
      WGC_MODE_PUSH_PULL: begin
        bridge = {db_hi && !st_q.pp_phase, db_hi && st_q.pp_phase,
                  db_hi && !st_q.pp_phase, db_hi && st_q.pp_phase};
      end
      WGC_MODE_FWD: begin
        bridge = {db_hi, 1'b0, 1'b0, 1'b1};
      end
      WGC_MODE_REV: begin
        bridge = {1'b0, 1'b1, db_hi, 1'b0};
      end
      default: begin
        bridge = `WGC_OUT_OFF;
      end
    endcase

    // In the steering modes polarity applies to steered pins only; unsteered pins stay low.
    if (st_q.mode == WGC_MODE_STEER || st_q.mode == WGC_MODE_SYNC_STEER) begin
      raw = st_q.steer_act & ({4{st_q.in_sync}} ^ st_q.pol);
    end else if (st_q.mode == WGC_MODE_RSV6 || st_q.mode == WGC_MODE_RSV7) begin
      raw = `WGC_OUT_OFF;
    end else begin
      raw = bridge ^ st_q.pol;
    end

    if (!st_q.enable) begin
      raw = `WGC_OUT_OFF;
    end
    st_d.out = raw;
  end

  // -----------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Dead-band counts carry no reset so they survive every reset.
  always_ff @(posedge clk_sys) begin
    db_q <= db_d;
  end

  assign reg_rdata = st_q.rdata;
  assign wave_out = st_q.out;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  disabled_outputs_off_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    !st_q.enable |=> st_q.out == `WGC_OUT_OFF)
    else $error("outputs active while the module is disabled");

  load_transfer_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (st_q.enable && st_q.load_req && edge_evt && !reg_wr)
      |=> !st_q.load_req && db_q.rise_act == $past(db_q.rise_buf)
          && db_q.fall_act == $past(db_q.fall_buf))
    else $error("buffered load did not transfer and clear on the input edge");

  load_gate_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (reg_wr && reg_addr == `WGC_ADDR_CTRL0 && !st_q.enable) |=> !st_q.load_req)
    else $error("load request taken while the module was disabled");

  push_pull_phase_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    rise_evt |=> st_q.pp_phase != $past(st_q.pp_phase))
    else $error("push-pull phase did not alternate on a rising edge");

  forward_bridge_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (st_q.enable && st_q.mode == WGC_MODE_FWD)
      |=> st_q.out[0] == !$past(st_q.pol[0]) && st_q.out[2] == $past(st_q.pol[2]))
    else $error("forward bridge static outputs wrong");

  reserved_off_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (st_q.mode == WGC_MODE_RSV6 || st_q.mode == WGC_MODE_RSV7) |=> st_q.out == 4'h0)
    else $error("reserved mode drove the outputs");

  steer_polarity_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (st_q.enable && st_q.mode == WGC_MODE_STEER && st_q.steer_act[0])
      |=> st_q.out[0] == ($past(st_q.in_sync) ^ $past(st_q.pol[0])))
    else $error("steered output polarity wrong");

  unused_bits_zero_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (reg_rd && reg_addr == `WGC_ADDR_CTRL0) |=> reg_rdata[5:3] == 3'h0)
    else $error("unimplemented control bits read as nonzero");

  steer_immediate_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    st_q.mode == WGC_MODE_STEER |=> st_q.steer_act == $past(st_q.steer_buf))
    else $error("plain steering change was delayed");

  steer_deferred_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (st_q.mode == WGC_MODE_SYNC_STEER && !rise_evt)
      |=> st_q.steer_act == $past(st_q.steer_act))
    else $error("synchronous steering changed away from a rising edge");

endmodule

`default_nettype wire

/* File: verification/tb.sv */
/*
  Self-checking bench for the waveform generator control block: register
  access, mode and polarity steering, dead-band latency and buffered load.
  Assumes wgc_ctrl with its package and register header on the include path.
*/
`timescale 1ns/1ps
`default_nettype none

`include "wgc_regs.svh"

module tb
  import wgc_pkg::*;
;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic wave_in = 1'b0;
  logic [3:0] wave_out;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int t0, t1, t2;
  localparam logic [3:0] MODE_PINS [8] = '{4'h0, 4'h0, 4'h1, 4'h4, 4'hA, 4'h0, 4'h0, 4'h0};

  wgc_ctrl wgc_ctrl_i (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .wave_in(wave_in),
    .wave_out(wave_out)
  );

  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  // ---------------------------------------------------------------
  // Report and hang guard
  // ---------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // The whole run needs about 1100 cycles; the margin covers slow settling.
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      err_count++;
      $display("mismatch at %0t: run timed out", $time);
      results();
    end
  end

  // ---------------------------------------------------------------
  // Bus tasks and comparisons
  // ---------------------------------------------------------------
  // All tasks are entered just after a rising edge and leave likewise.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic chk_reg(input logic [2:0] a, input logic [7:0] exp);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    total_checks++;
    if (reg_rdata !== exp) begin
      err_count++;
      $display("mismatch at %0t: reg %0d read %h want %h", $time, a, reg_rdata, exp);
    end
  endtask

  task automatic chk_pin(input logic [3:0] exp);
    total_checks++;
    if (wave_out !== exp) begin
      err_count++;
      $display("mismatch at %0t: pins %h want %h", $time, wave_out, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    total_checks++;
    if (got != exp) begin
      err_count++;
      $display("mismatch at %0t: latency %0d want %0d", $time, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // Raises the input and counts cycles until output D rises.
  task automatic rise_delay(output int n);
    n = 0;
    wave_in <= 1'b1;
    while (n < 200) begin
      @(posedge clk_sys);
      n++;
      #1;
      if (wave_out[3] === 1'b1) break;
    end
    settle(1);
  endtask

  task automatic test_end(input string name);
    $display("test %s finished, mismatches so far %0d", name, err_count);
  endtask

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    settle(6);
    sys_rst <= 1'b0;
    settle(1);
    chk_reg(`WGC_ADDR_CTRL0, 8'h00);
    chk_reg(`WGC_ADDR_CTRL1, 8'h00);
    chk_reg(3'h5, 8'h00);
    chk_reg(3'h7, 8'h00);
    test_end("reset");

    wr(`WGC_ADDR_DB_RISE, 8'hC0);
    chk_reg(`WGC_ADDR_DB_RISE, 8'h00);
    wr(`WGC_ADDR_DB_FALL, 8'hC3);
    chk_reg(`WGC_ADDR_DB_FALL, 8'h03);
    wr(`WGC_ADDR_CTRL1, 8'hDF);
    chk_reg(`WGC_ADDR_CTRL1, 8'h0F);
    wr(`WGC_ADDR_CTRL1, 8'h00);
    wr(`WGC_ADDR_CTRL0, 8'h38);
    chk_reg(`WGC_ADDR_CTRL0, 8'h00);
    wr(`WGC_ADDR_CTRL0, 8'hC0);
    chk_reg(`WGC_ADDR_CTRL0, 8'h80);
    test_end("fields");

    wr(`WGC_ADDR_STEER, 8'h0F);
    for (int m = 0; m < 8; m++) begin
      wr(`WGC_ADDR_CTRL0, {5'h10, 3'(m)});
      chk_reg(`WGC_ADDR_CTRL0, {5'h10, 3'(m)});
      settle(80);
      chk_pin(MODE_PINS[m]);
    end
    test_end("modes");

    wr(`WGC_ADDR_CTRL0, 8'h80);
    wave_in <= 1'b1;
    settle(8);
    chk_pin(4'hF);
    wr(`WGC_ADDR_CTRL1, 8'h01);
    settle(8);
    chk_pin(4'hE);
    chk_reg(`WGC_ADDR_CTRL1, 8'h21);
    wave_in <= 1'b0;
    settle(8);
    chk_pin(4'h1);
    wr(`WGC_ADDR_CTRL1, 8'h00);
    wave_in <= 1'b1;
    settle(8);
    wr(`WGC_ADDR_STEER, 8'h05);
    settle(2);
    chk_pin(4'h5);
    test_end("steer");

    wr(`WGC_ADDR_STEER, 8'h00);
    settle(4);
    chk_pin(4'h0);
    wr(`WGC_ADDR_CTRL0, 8'h81);
    wr(`WGC_ADDR_STEER, 8'h0F);
    settle(8);
    chk_pin(4'h0);
    wave_in <= 1'b0;
    settle(8);
    chk_pin(4'h0);
    wave_in <= 1'b1;
    settle(8);
    chk_pin(4'hF);
    wr(`WGC_ADDR_CTRL0, 8'h01);
    settle(8);
    chk_pin(4'h0);
    test_end("sync steer");

    wave_in <= 1'b0;
    wr(`WGC_ADDR_CTRL0, 8'h82);
    settle(80);
    rise_delay(t0);
    wr(`WGC_ADDR_DB_RISE, 8'h0A);
    chk_reg(`WGC_ADDR_DB_RISE, 8'h0A);
    wave_in <= 1'b0;
    settle(80);
    rise_delay(t1);
    chk_cnt(t1, t0);
    settle(80);
    wr(`WGC_ADDR_CTRL0, 8'hC2);
    chk_reg(`WGC_ADDR_CTRL0, 8'hC2);
    wave_in <= 1'b0;
    settle(80);
    chk_reg(`WGC_ADDR_CTRL0, 8'h82);
    rise_delay(t2);
    chk_cnt(t2, t0 + 10);
    test_end("dead-band");

    sys_rst <= 1'b1;
    settle(2);
    sys_rst <= 1'b0;
    settle(1);
    chk_pin(4'h0);
    chk_reg(`WGC_ADDR_CTRL0, 8'h00);
    chk_reg(`WGC_ADDR_DB_RISE, 8'h0A);
    chk_reg(`WGC_ADDR_DB_FALL, 8'h03);
    test_end("warm reset");
    results();
  end
endmodule

`default_nettype wire
